// ===== adc_monitor_port_controller.sv
// How it works
// - Sweep reads temperature and three supply results
// - Sweep also reads auxiliary channels zero to three
// - Converter runs continuous sequence, no retriggering
// - Config words keep alarm, sequencer, divider settings
// - Averaging recommended on for sensor channels
// - Averaging on at power-up; write-back disables it
// - Read config 0x40 once busy is low
// - Write back returned word masked with 03FF
// - Strobe with write-enable, then await data-ready
// - Single-cycle pulses via two-bit right shifter
// - All port transfers on the shared clock
// - After end-of-sequence read results from address zero
`timescale 1ns/1ps
`include "adc_monitor_defines.svh"

module adc_monitor_port_controller #(
  parameter bit CLEAR_AVERAGING = 1'b1
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // Converter configuration port
  output adc_monitor_pkg::port_addr_t port_addr_o,
  output logic port_strobe_o,
  output logic port_write_enable_o,
  output adc_monitor_pkg::port_word_t port_write_word_o,
  input wire adc_monitor_pkg::port_word_t port_read_word_i,
  input wire logic port_ready_i,
  input wire logic port_busy_i,
  input wire logic end_of_seq_i,
  input wire adc_monitor_pkg::alarm_t alarm_vector_i,
  // User side
  input wire adc_monitor_pkg::result_index_t result_index_i,
  output adc_monitor_pkg::port_word_t result_word_o,
  output adc_monitor_pkg::alarm_t alarm_o,
  output logic init_done_o,
  output logic sweep_done_o
);
  import adc_monitor_pkg::*;

  ctrl_state_t state;
  logic [1:0] strobe_pulse;
  logic [1:0] write_pulse;
  result_index_t result_index;
  port_addr_t port_addr;
  port_word_t write_word;
  logic init_done;
  logic sweep_done;
  alarm_t alarm_seen;

  result_store_if store_bus ();

  function automatic port_addr_t result_addr(input result_index_t idx);
    port_addr_t a;
    a = `RESULT_TEMP_ADDR;
    case (idx)
      3'h0: a = `RESULT_TEMP_ADDR;
      3'h1: a = `RESULT_CORE_ADDR;
      3'h2: a = `RESULT_AUX_SUPPLY_ADDR;
      3'h3: a = `RESULT_BLOCK_MEMORY_ADDR;
      3'h4: a = `RESULT_AUX0_ADDR;
      3'h5: a = `RESULT_AUX1_ADDR;
      3'h6: a = `RESULT_AUX2_ADDR;
      default: a = `RESULT_AUX3_ADDR;
    endcase
    return a;
  endfunction

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      state <= INIT_READ;
      port_addr <= `CONFIG_WORD_ZERO_ADDR;
      result_index <= '0;
    end else begin
      case (state)
        INIT_READ: begin
          port_addr <= `CONFIG_WORD_ZERO_ADDR;
          if (!port_busy_i) begin
            state <= INIT_READ_WAIT;
          end
        end
        INIT_READ_WAIT: begin
          if (port_ready_i) begin
            port_addr <= `CONFIG_WORD_ZERO_ADDR;
            state <= INIT_WRITE_WAIT;
          end
        end
        INIT_WRITE_WAIT: begin
          if (port_ready_i) begin
            result_index <= '0;
            state <= RESULT_READ;
          end
        end
        RESULT_READ: begin
          port_addr <= result_addr(result_index);
          if (result_index != '0 || end_of_seq_i) begin
            state <= RESULT_WAIT;
          end
        end
        RESULT_WAIT: begin
          if (port_ready_i) begin
            result_index <= result_index + 3'h1;
            state <= RESULT_READ;
          end
        end
        default: state <= INIT_READ;
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      strobe_pulse <= `PULSE_IDLE;
      write_pulse <= `PULSE_IDLE;
    end else if (state == INIT_READ && !port_busy_i) begin
      strobe_pulse <= `PULSE_LOAD;
    end else if (state == INIT_READ_WAIT && port_ready_i) begin
      strobe_pulse <= `PULSE_LOAD;
      write_pulse <= `PULSE_LOAD;
    end else if (state == RESULT_READ && (result_index != '0 || end_of_seq_i)) begin
      strobe_pulse <= `PULSE_LOAD;
    end else begin
      strobe_pulse <= {1'b0, strobe_pulse[1]};
      write_pulse <= {1'b0, write_pulse[1]};
    end
  end

  // Write-back data
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      write_word <= '0;
    end else if (state == INIT_READ_WAIT && port_ready_i) begin
      write_word <= CLEAR_AVERAGING ? (port_read_word_i & `AVERAGING_CLEAR_MASK) : port_read_word_i;
    end
  end

  // Status flags
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      init_done <= 1'b0;
      sweep_done <= 1'b0;
      alarm_seen <= '0;
    end else begin
      if (state == INIT_WRITE_WAIT && port_ready_i) begin
        init_done <= 1'b1;
      end
      sweep_done <= (state == RESULT_WAIT && port_ready_i && result_index == `RESULT_LAST);
      alarm_seen <= alarm_vector_i;
    end
  end

  assign store_bus.wr_en = (state == RESULT_WAIT) && port_ready_i;
  assign store_bus.wr_index = result_index;
  assign store_bus.wr_data = port_read_word_i;
  assign store_bus.rd_index = result_index_i;

  result_store #(
    .DEPTH(`RESULT_COUNT)
  ) u_store (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .bus(store_bus.store)
  );

  assign port_addr_o = port_addr;
  assign port_strobe_o = strobe_pulse[0];
  assign port_write_enable_o = write_pulse[0];
  assign port_write_word_o = write_word;
  assign result_word_o = store_bus.rd_data;
  assign alarm_o = alarm_seen;
  assign init_done_o = init_done;
  assign sweep_done_o = sweep_done;

  // Checking helpers
  logic pending;
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      pending <= 1'b0;
    end else if (port_strobe_o) begin
      pending <= 1'b1;
    end else if (port_ready_i) begin
      pending <= 1'b0;
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);

  strobe_single_pulse_a: assert property (port_strobe_o |=> !port_strobe_o)
    else $error("strobe lasted more than one cycle");
  write_with_strobe_a: assert property (port_write_enable_o |-> port_strobe_o)
    else $error("write-enable without strobe");
  write_mask_a: assert property (port_write_enable_o && CLEAR_AVERAGING |-> (port_write_word_o & 16'hFC00) == 16'h0000)
    else $error("averaging bits not cleared");
  write_addr_a: assert property (port_write_enable_o |-> port_addr_o == `CONFIG_WORD_ZERO_ADDR)
    else $error("write-back to wrong address");
  init_read_issue_a: assert property (state == INIT_READ && !port_busy_i |-> ##2 port_strobe_o && !port_write_enable_o && port_addr_o == `CONFIG_WORD_ZERO_ADDR)
    else $error("initial read not presented");
  busy_hold_a: assert property (state == INIT_READ && port_busy_i |=> state == INIT_READ && !port_strobe_o)
    else $error("left initial read while busy");
  one_outstanding_a: assert property (port_strobe_o |-> !pending)
    else $error("strobe before data-ready");
  reset_clear_a: assert property ($past(reset_i) |-> !port_strobe_o && !port_write_enable_o && port_write_word_o == 16'h0000 && state == INIT_READ)
    else $error("reset did not clear controller");
  sweep_start_a: assert property (state == RESULT_READ && result_index == 3'h0 && !end_of_seq_i |=> state == RESULT_READ && !port_strobe_o)
    else $error("sweep started without end-of-sequence");
  first_result_addr_a: assert property (state == RESULT_READ && result_index == 3'h0 && end_of_seq_i |=> ##1 port_strobe_o && port_addr_o == `RESULT_TEMP_ADDR)
    else $error("sweep not started at address zero");

  write_back_c: cover property (port_write_enable_o ##[1:20] init_done_o);
  busy_wait_c: cover property (state == INIT_READ && port_busy_i ##1 state == INIT_READ_WAIT);
  full_sweep_c: cover property (sweep_done_o);
endmodule

// ===== adc_monitor_defines.svh
`ifndef ADC_MONITOR_DEFINES_SVH
`define ADC_MONITOR_DEFINES_SVH

// Port address and data widths
`define PORT_ADDR_W 7
`define PORT_DATA_W 16

// Configuration word offsets
`define CONFIG_WORD_ZERO_ADDR 7'h40
`define CONFIG_WORD_ONE_ADDR 7'h41
`define CONFIG_WORD_TWO_ADDR 7'h42

// Write-back mask that clears the averaging field
`define AVERAGING_CLEAR_MASK 16'h03FF

// Result offsets, read in this order
`define RESULT_TEMP_ADDR 7'h00
`define RESULT_CORE_ADDR 7'h01
`define RESULT_AUX_SUPPLY_ADDR 7'h02
`define RESULT_BLOCK_MEMORY_ADDR 7'h06
`define RESULT_AUX0_ADDR 7'h10
`define RESULT_AUX1_ADDR 7'h11
`define RESULT_AUX2_ADDR 7'h12
`define RESULT_AUX3_ADDR 7'h13

// Pulse shift register
`define PULSE_LOAD 2'h2
`define PULSE_IDLE 2'h0
`define RESULT_COUNT 8
`define RESULT_INDEX_W 3
`define RESULT_LAST 3'h7
`define ALARM_W 8

`endif

// ===== adc_monitor_pkg.sv
`include "adc_monitor_defines.svh"

package adc_monitor_pkg;
  typedef enum logic [2:0] {
    INIT_READ,
    INIT_READ_WAIT,
    INIT_WRITE_WAIT,
    RESULT_READ,
    RESULT_WAIT
  } ctrl_state_t;

  typedef logic [`PORT_ADDR_W-1:0] port_addr_t;
  typedef logic [`PORT_DATA_W-1:0] port_word_t;
  typedef logic [`RESULT_INDEX_W-1:0] result_index_t;
  typedef logic [`ALARM_W-1:0] alarm_t;
endpackage

// ===== result_store_if.sv
`timescale 1ns/1ps
`include "adc_monitor_defines.svh"

interface result_store_if;
  import adc_monitor_pkg::*;
  logic wr_en;
  result_index_t wr_index;
  port_word_t wr_data;
  result_index_t rd_index;
  port_word_t rd_data;

  modport ctrl (output wr_en, output wr_index, output wr_data, output rd_index, input rd_data);
  modport store (input wr_en, input wr_index, input wr_data, input rd_index, output rd_data);
endinterface

// ===== result_store.sv
`timescale 1ns/1ps
`include "adc_monitor_defines.svh"

module result_store #(
  parameter int DEPTH = `RESULT_COUNT
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // Store port
  result_store_if.store bus
);
  import adc_monitor_pkg::*;

  port_word_t mem [DEPTH];

  always_ff @(posedge core_clk_i) begin
    if (bus.wr_en) begin
      mem[bus.wr_index] <= bus.wr_data;
    end
  end

  // Registered read data
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      bus.rd_data <= '0;
    end else begin
      bus.rd_data <= mem[bus.rd_index];
    end
  end
endmodule

// ===== adc_monitor_model.sv
`timescale 1ns/1ps
module adc_monitor_model
  import adc_monitor_pkg::*;
(
  // Clock and test controls
  input wire logic core_clk_i,
  input wire logic busy_i,
  input wire logic [3:0] latency_i,
  input wire alarm_t alarm_set_i,
  // Configuration port
  input wire port_addr_t port_addr_i,
  input wire logic port_strobe_i,
  input wire logic port_write_enable_i,
  input wire port_word_t port_write_word_i,
  output port_word_t port_read_word_o,
  output logic port_ready_o,
  output logic port_busy_o,
  output alarm_t alarm_vector_o
);
  port_word_t config_word_zero = 16'hF3C5;
  port_word_t rd_word = 16'h0000;
  port_addr_t pend_addr = 7'h00;
  logic [3:0] wait_cnt = 4'h0;
  logic pending = 1'b0;
  logic ready_q = 1'b0;
  logic last_strobe = 1'b0;
  int strobe_count = 0;
  int write_count = 0;
  int protocol_errs = 0;
  assign port_read_word_o = rd_word;
  assign port_ready_o = ready_q;
  assign port_busy_o = busy_i;
  assign alarm_vector_o = alarm_set_i;
  always @(posedge core_clk_i) begin
    ready_q <= 1'b0;
    rd_word <= ~rd_word;
    last_strobe <= port_strobe_i;
    if (pending) begin
      if (wait_cnt == 4'h0) begin
        ready_q <= 1'b1;
        // Result words carry the latency so that stale sweeps show up
        rd_word <= (pend_addr == 7'h40) ? config_word_zero : {9'h1A5 ^ {5'h00, latency_i}, pend_addr};
        pending <= 1'b0;
      end else begin
        wait_cnt <= wait_cnt - 4'h1;
      end
    end
    if (port_write_enable_i && !port_strobe_i) begin
      protocol_errs <= protocol_errs + 1;
    end
    if (port_strobe_i) begin
      strobe_count <= strobe_count + 1;
      if (pending || last_strobe) begin
        protocol_errs <= protocol_errs + 1;
      end
      pending <= 1'b1;
      wait_cnt <= latency_i;
      pend_addr <= port_addr_i;
      if (port_write_enable_i) begin
        write_count <= write_count + 1;
        if (port_addr_i == 7'h40) begin
          config_word_zero <= port_write_word_i;
        end
      end
    end
  end
endmodule

// ===== testbench.sv
`timescale 1ns/1ps
module testbench;
  import adc_monitor_pkg::*;
  logic core_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic busy = 1'b1;
  logic end_of_seq = 1'b0;
  logic [3:0] latency = 4'h1;
  alarm_t alarm_set = 8'h00;
  result_index_t result_index = 3'h0;
  port_addr_t addr;
  logic strobe, we, ready, busy_w, init_done, sweep_done;
  port_word_t wword, rword, result_word, w;
  alarm_t alarm_vec, alarm_out;
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;
  port_addr_t exp_addr [8] = '{7'h00, 7'h01, 7'h02, 7'h06, 7'h10, 7'h11, 7'h12, 7'h13};

  adc_monitor_port_controller #(.CLEAR_AVERAGING(1'b1)) DUT (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .port_addr_o(addr), .port_strobe_o(strobe), .port_write_enable_o(we), .port_write_word_o(wword),
    .port_read_word_i(rword), .port_ready_i(ready), .port_busy_i(busy_w), .end_of_seq_i(end_of_seq),
    .alarm_vector_i(alarm_vec), .result_index_i(result_index), .result_word_o(result_word),
    .alarm_o(alarm_out), .init_done_o(init_done), .sweep_done_o(sweep_done));
  adc_monitor_model conv (.core_clk_i(core_clk_i), .busy_i(busy), .latency_i(latency),
    .alarm_set_i(alarm_set), .port_addr_i(addr), .port_strobe_i(strobe), .port_write_enable_i(we),
    .port_write_word_i(wword), .port_read_word_o(rword), .port_ready_o(ready), .port_busy_o(busy_w),
    .alarm_vector_o(alarm_vec));

  initial begin
    forever #4 core_clk_i = ~core_clk_i;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wait_for(input bit sweep, input int lim);
    int n = 0;
    do begin
      tick(1);
      n++;
    end while ((sweep ? sweep_done : init_done) !== 1'b1 && n < lim);
    check({15'h0000, sweep ? sweep_done : init_done}, 16'h0001);
  endtask

  task automatic test_done();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      test_done();
    end
  end

  initial begin
    tick(8);
    reset_i = 1'b0;
    tick(12);
    check(16'(conv.strobe_count), 16'h0000);
    busy = 1'b0;
    wait_for(1'b0, 60);
    check(conv.config_word_zero, 16'hF3C5 & 16'h03FF);
    check(wword, 16'hF3C5 & 16'h03FF);
    check(16'(conv.write_count), 16'h0001);
    tick(20);
    check(16'(conv.strobe_count), 16'h0002);
    alarm_set = 8'hA5;
    tick(2);
    check({8'h00, alarm_out}, 16'h00A5);
    for (int s = 0; s < 2; s++) begin
      latency = (s == 0) ? 4'h1 : 4'h6;
      end_of_seq = 1'b1;
      tick(1);
      end_of_seq = 1'b0;
      wait_for(1'b1, 300);
      for (int i = 0; i < 8; i++) begin
        result_index = 3'(i);
        tick(2);
        check(result_word, {9'h1A5 ^ {5'h00, latency}, exp_addr[i]});
      end
    end
    check(16'(conv.strobe_count), 16'h0012);
    end_of_seq = 1'b1;
    tick(1);
    end_of_seq = 1'b0;
    tick(5);
    reset_i = 1'b1;
    tick(1);
    check({14'h0000, strobe, we}, 16'h0000);
    check(wword, 16'h0000);
    check({15'h0000, init_done}, 16'h0000);
    tick(7);
    reset_i = 1'b0;
    wait_for(1'b0, 60);
    check(conv.config_word_zero, 16'h03C5);
    check(16'(conv.protocol_errs), 16'h0000);
    test_done();
  end
endmodule
